// file: adc_ctrl_map.vh
// constants for the integrating converter control block
// assumes inclusion by adc_serial_ctrl.v only
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// command byte, bits 7:6 select the command
`define CMD_OP_HI 7
`define CMD_OP_LO 6
`define CMD_OP_CONFIG 2'h0
`define CMD_OP_USER 2'h1
`define CMD_OP_READSEL 2'h2
`define CMD_OP_NONE 2'h3
// config command fields
`define CFG_MODE50_BIT 0
`define CFG_START_BIT 1
// reset values
`define RST_MODE50 1'b0
`define RST_USER_OUT 4'h0
`define RST_READ_SEL 2'h3
`define RST_IN_SHIFT 8'hff
// output register indexes
`define OREG_RESULT_HI 2'h0
`define OREG_RESULT_MID 2'h1
`define OREG_RESULT_LO 2'h2
`define OREG_STATUS 2'h3
// integration lengths in oscillator periods
`define INTEG_COUNT_50HZ 18'd655
`define INTEG_COUNT_60HZ 18'd545
// deintegration overrange limit in oscillator periods
`define DEINT_MAX_COUNT 18'h3ffff

`endif

// file: sync3.v
// three-stage synchroniser with agreement filter
// assumes d is asynchronous to clk
`timescale 1ns/10ps
module sync3 #(
  parameter INIT = 1'b0
) (
  input wire clk,
  input wire rst,
  input wire d,
  output wire q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;

  always @(posedge clk) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      lvl_q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // level moves only once stages two and three agree
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign q = lvl_q;
endmodule // sync3

// file: adc_serial_ctrl.v
// control logic of a dual-slope integrating converter with four-wire serial port
// assumes all serial pins, oscillator and comparator inputs are asynchronous to clk
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module adc_serial_ctrl (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire din,
  output wire dout_o,
  output wire dout_oe,
  input wire oscillator_input,
  output wire oscillator_output,
  input wire zero_cross,
  input wire input_negative,
  output wire integrate_input,
  output wire deintegrate_ref,
  output wire user_output_0,
  output wire user_output_1,
  output wire user_output_2,
  output wire user_output_3,
  output wire eoc,
  output wire overrange,
  output wire busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_INTEG = 2'h1;
  localparam ST_DEINT = 2'h2;

  wire cs_n_f;
  wire sclk_f;
  wire din_f;
  wire osc_f;
  wire zc_f;
  wire neg_f;

  reg cs_n_prev_q;
  reg sclk_prev_q;
  reg osc_prev_q;
  reg [7:0] in_shift_q;
  reg [7:0] out_shift_q;
  reg [1:0] read_sel_q;
  reg mode50_q;
  reg [3:0] user_out_q;
  reg start_q;
  reg start_pend_q;
  reg [1:0] state_q;
  reg [17:0] count_q;
  reg [17:0] result_q;
  reg sign_q;
  reg eoc_q;
  reg over_q;
  reg integ_q;
  reg deint_q;
  reg osc_drv_q;
  reg [7:0] out_sel_data;
  reg [17:0] integ_len;

  sync3 #(.INIT(1'b1)) u_sync_cs (.clk(clk), .rst(rst), .d(cs_n), .q(cs_n_f));
  sync3 #(.INIT(1'b0)) u_sync_sclk (.clk(clk), .rst(rst), .d(sclk), .q(sclk_f));
  sync3 #(.INIT(1'b0)) u_sync_din (.clk(clk), .rst(rst), .d(din), .q(din_f));
  sync3 #(.INIT(1'b0)) u_sync_osc (.clk(clk), .rst(rst), .d(oscillator_input), .q(osc_f));
  sync3 #(.INIT(1'b0)) u_sync_zc (.clk(clk), .rst(rst), .d(zero_cross), .q(zc_f));
  sync3 #(.INIT(1'b0)) u_sync_neg (.clk(clk), .rst(rst), .d(input_negative), .q(neg_f));

  wire selected = ~cs_n_f;
  wire cs_rise = cs_n_f & ~cs_n_prev_q;
  wire cs_fall = ~cs_n_f & cs_n_prev_q;
  wire sclk_rise = selected & sclk_f & ~sclk_prev_q;
  wire sclk_fall = selected & ~sclk_f & sclk_prev_q;
  wire osc_tick = osc_f & ~osc_prev_q;

  always @(posedge clk) begin
    if (rst) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
      osc_drv_q <= 1'b1;
    end else begin
      cs_n_prev_q <= cs_n_f;
      sclk_prev_q <= sclk_f;
      osc_prev_q <= osc_f;
      osc_drv_q <= ~osc_f;
    end
  end

  // output register selected by the last read-select command
  always @* begin
    case (read_sel_q)
      `OREG_RESULT_HI: out_sel_data = {5'h00, sign_q, result_q[17:16]};
      `OREG_RESULT_MID: out_sel_data = result_q[15:8];
      `OREG_RESULT_LO: out_sel_data = result_q[7:0];
      default: out_sel_data = {eoc_q, (state_q != ST_IDLE), mode50_q, over_q, user_out_q};
    endcase
  end

  // serial shifters
  always @(posedge clk) begin
    if (rst) begin
      in_shift_q <= `RST_IN_SHIFT;
      out_shift_q <= 8'h00;
    end else begin
      // empty frame decodes as no command
      if (cs_fall) begin
        in_shift_q <= `RST_IN_SHIFT;
      end else if (sclk_rise) begin
        in_shift_q <= {in_shift_q[6:0], din_f};
      end
      if (cs_fall) begin
        out_shift_q <= out_sel_data;
      end else if (sclk_fall) begin
        out_shift_q <= {out_shift_q[6:0], 1'b0};
      end
    end
  end

  assign dout_oe = selected;
  assign dout_o = out_shift_q[7];

  // command decode at end of frame
  always @(posedge clk) begin
    if (rst) begin
      read_sel_q <= `RST_READ_SEL;
      mode50_q <= `RST_MODE50;
      user_out_q <= `RST_USER_OUT;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      // commit last byte at select rise
      if (cs_rise) begin
        case (in_shift_q[`CMD_OP_HI:`CMD_OP_LO])
          `CMD_OP_CONFIG: begin
            mode50_q <= in_shift_q[`CFG_MODE50_BIT];
            start_q <= in_shift_q[`CFG_START_BIT];
          end
          `CMD_OP_USER: begin
            user_out_q <= in_shift_q[3:0];
          end
          `CMD_OP_READSEL: begin
            read_sel_q <= in_shift_q[1:0];
          end
          default: begin
            read_sel_q <= read_sel_q;
          end
        endcase
      end
    end
  end

  always @* begin
    if (mode50_q) begin
      integ_len = `INTEG_COUNT_50HZ;
    end else begin
      integ_len = `INTEG_COUNT_60HZ;
    end
  end

  // conversion sequencer, counts oscillator periods
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      start_pend_q <= 1'b0;
      count_q <= 18'h00000;
      result_q <= 18'h00000;
      sign_q <= 1'b0;
      eoc_q <= 1'b0;
      over_q <= 1'b0;
      integ_q <= 1'b0;
      deint_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            start_pend_q <= 1'b1;
            eoc_q <= 1'b0;
          end
          // integration starts on an oscillator edge
          if (start_pend_q && osc_tick) begin
            state_q <= ST_INTEG;
            start_pend_q <= 1'b0;
            count_q <= 18'h00000;
            over_q <= 1'b0;
            integ_q <= 1'b1;
          end
        end
        ST_INTEG: begin
          if (osc_tick) begin
            if (count_q == integ_len - 18'd1) begin
              state_q <= ST_DEINT;
              count_q <= 18'h00000;
              sign_q <= neg_f;
              integ_q <= 1'b0;
              deint_q <= 1'b1;
            end else begin
              count_q <= count_q + 18'd1;
            end
          end
        end
        ST_DEINT: begin
          if (osc_tick) begin
            if (zc_f || count_q == `DEINT_MAX_COUNT) begin
              state_q <= ST_IDLE;
              result_q <= count_q;
              over_q <= ~zc_f;
              deint_q <= 1'b0;
              eoc_q <= 1'b1;
            end else begin
              count_q <= count_q + 18'd1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          integ_q <= 1'b0;
          deint_q <= 1'b0;
        end
      endcase
    end
  end

  assign integrate_input = integ_q;
  assign deintegrate_ref = deint_q;
  assign oscillator_output = osc_drv_q;
  assign user_output_0 = user_out_q[0];
  assign user_output_1 = user_out_q[1];
  assign user_output_2 = user_out_q[2];
  assign user_output_3 = user_out_q[3];
  assign eoc = eoc_q;
  assign overrange = over_q;
  assign busy = (state_q != ST_IDLE);
endmodule // adc_serial_ctrl

// file: adc_serial_ctrl_assertions.sv
// port checker for the converter control block
// assumes one clock domain, bound to adc_serial_ctrl
`timescale 1ns/10ps
module adc_serial_ctrl_assertions (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire dout_oe,
  input wire integrate_input,
  input wire deintegrate_ref,
  input wire user_output_0,
  input wire eoc,
  input wire busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_int_end;
    $fell(integrate_input);
  endsequence
  sequence s_deint_end;
    $fell(deintegrate_ref);
  endsequence
  chk_oe_off: assert property (cs_n [*6] |-> !dout_oe)
    else $error("dout driven while idle");
  chk_oe_on: assert property (!cs_n [*6] |-> dout_oe)
    else $error("dout not driven in frame");
  chk_int_deint: assert property (s_int_end |-> ##[0:1] deintegrate_ref)
    else $error("no deintegration after input phase");
  chk_done_eoc: assert property (s_deint_end |-> ##[0:1] eoc)
    else $error("no done after deintegration");
  chk_eoc_idle: assert property (eoc |-> !deintegrate_ref)
    else $error("done while deintegrating");
  chk_user_hold: assert property ($changed(user_output_0) |-> cs_n && $past(cs_n, 4))
    else $error("user output moved inside frame");
  chk_start_integ: assert property ($rose(busy) |-> integrate_input)
    else $error("conversion did not start with input phase");
  chk_eoc_clear: assert property ($rose(busy) |-> ##[0:2] !eoc)
    else $error("done kept after start");
endmodule // adc_serial_ctrl_assertions
bind adc_serial_ctrl adc_serial_ctrl_assertions chk (.clk, .rst, .cs_n, .dout_oe, .integrate_input,
  .deintegrate_ref, .user_output_0, .eoc, .busy);

// file: serial_host.sv
// host model for the four-wire serial port
// assumes 100 MHz clk, bit clock of 8 clk periods
`timescale 1ns/10ps
module serial_host (
  input wire clk,
  input wire dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge clk) cs_n <= 1'b0;
    repeat (60) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      din <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      rx[i] = dout;
      @(posedge clk) sclk <= 1'b0;
    end
    repeat (50) @(posedge clk);
    cs_n <= 1'b1;
    din <= ~din;
    repeat (110) @(posedge clk);
  endtask
endmodule // serial_host

// file: adc_serial_ctrl_bench.sv
// self-checking bench for the converter control block
// assumes serial_host drives the serial pins
`timescale 1ns/10ps
module adc_serial_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic zero_cross = 1'b0;
  logic [2:0] osc_div = 3'h0;
  logic osc_q = 1'b0;
  logic osc_out_q = 1'b0;
  logic input_negative = 1'b0;
  logic cs_n, sclk, din;
  wire dout, dout_o, dout_oe, integrate_input, deintegrate_ref, eoc, overrange, busy, oscillator_output;
  wire user_output_0, user_output_1, user_output_2, user_output_3;
  integer n_fail = 0;
  integer n_checks = 0;
  integer n_int = 0;
  integer n_osc = 0;
  integer base, base_osc, t, i;
  logic [7:0] rx;
  logic [3:0] prev = 4'h0;
  logic [11:0] rows [0:3] = '{12'h4aa, 12'h455, 12'h4ff, 12'h499};
  initial begin
    forever #5 clk = ~clk;
  end
  assign dout = dout_oe ? dout_o : 1'bz;
  serial_host host (.clk, .dout, .cs_n, .sclk, .din);
  adc_serial_ctrl dut (.clk, .rst, .cs_n, .sclk, .din, .dout_o, .dout_oe, .oscillator_input(osc_div[2]),
    .oscillator_output, .zero_cross, .input_negative, .integrate_input, .deintegrate_ref,
    .user_output_0, .user_output_1, .user_output_2, .user_output_3, .eoc, .overrange, .busy);
  always @(posedge clk) begin
    osc_div <= osc_div + 3'h1;
    osc_q <= osc_div[2];
    osc_out_q <= oscillator_output;
    if (osc_div[2] && !osc_q && integrate_input === 1'b1) n_int <= n_int + 1;
    if (oscillator_output && !osc_out_q && integrate_input === 1'b1) n_osc <= n_osc + 1;
  end
  task check(input logic [17:0] seen, input logic [17:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wait_for(input logic done);
    for (t = 0; t < 9000 && (done ? eoc : deintegrate_ref) !== 1'b1; t++) @(posedge clk);
    if (t == 9000) begin
      n_fail++;
      complete_run;
    end
  endtask
  task idle_check;
    check({dout_oe, eoc, busy, user_output_3, user_output_2, user_output_1, user_output_0}, 0, "idle");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    idle_check();
    foreach (rows[i]) begin
      host.xfer(rows[i][11:4], rx);
      check(rx, {4'h0, prev}, "status");
      check({user_output_3, user_output_2, user_output_1, user_output_0}, rows[i][3:0], "user");
      prev = rows[i][3:0];
    end
    for (i = 1; i >= 0; i--) begin
      base = n_int;
      base_osc = n_osc;
      input_negative <= !i[0];
      host.xfer({6'h0, 1'b1, i[0]}, rx);
      wait_for(1'b0);
      repeat (160) @(posedge clk);
      zero_cross <= 1'b1;
      wait_for(1'b1);
      zero_cross <= 1'b0;
      check(18'(n_int - base), i ? 18'd655 : 18'd545, "integration");
      check(18'(n_osc - base_osc), i ? 18'd655 : 18'd545, "osc drive");
      check({eoc, overrange, busy}, 3'h4, "done flags");
    end
    host.xfer(8'h80, rx);
    host.xfer(8'h81, rx);
    check(rx, 8'h04, "result high");
    host.xfer(8'h82, rx);
    check(rx, 8'h00, "result mid");
    host.xfer(8'h83, rx);
    check(rx, 8'h14, "result low");
    host.xfer(8'hff, rx);
    check(rx, 8'h89, "status");
    check(user_output_3 && user_output_0, 1'b1, "user kept");
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    idle_check();
    host.xfer(8'hff, rx);
    check(rx, 8'h00, "status after reset");
    complete_run();
  end
endmodule // adc_serial_ctrl_bench
